// file: mspp_defines.svh
// Offsets, field positions, reset values and widths for the mode-shared ports
`ifndef MSPP_DEFINES_SVH
`define MSPP_DEFINES_SVH

// ****************************************
// Register bus geometry
// ****************************************
`define MSPP_ADDR_W 4
`define MSPP_DATA_W 8

// ****************************************
// Register offsets
// ****************************************
`define MSPP_OFS_HIGH_LATCH 4'h0
`define MSPP_OFS_LOW_LATCH 4'h1
`define MSPP_OFS_DBUS_LATCH 4'h2
`define MSPP_OFS_DBUS_DIR 4'h3
`define MSPP_OFS_SER_LATCH 4'h4
`define MSPP_OFS_SER_DIR 4'h5
`define MSPP_OFS_ANALOG_IN 4'h6
`define MSPP_OFS_OPTION2 4'h7
`define MSPP_OFS_SYNC_CTRL 4'h8
`define MSPP_OFS_MODE 4'h9

// ****************************************
// Field positions
// ****************************************
`define MSPP_DBUS_OD_BIT 5
`define MSPP_SER_OD_BIT 5
`define MSPP_DBUS_W 8
`define MSPP_SER_W 6

// ****************************************
// Reset values
// ****************************************
`define MSPP_RST_LATCH 8'h00
`define MSPP_RST_DIR 8'h00
`define MSPP_RST_SER 6'h00
`define MSPP_RST_CTRL 8'h00

// ****************************************
// Mode strap encodings
// ****************************************
`define MSPP_STRAP_BOOT 2'h0
`define MSPP_STRAP_SINGLE 2'h1
`define MSPP_STRAP_TEST 2'h2
`define MSPP_STRAP_EXP 2'h3

`endif

// file: mspp_pkg.sv
// Types shared by the mode-shared port block
package mspp_pkg;

   // ****************************************
   // Operating modes, one-hot
   // ****************************************
   typedef enum logic [3:0] {
      MODE_SINGLE = 4'h1,
      MODE_EXPANDED = 4'h2,
      MODE_BOOT = 4'h4,
      MODE_TEST = 4'h8
   } mspp_mode_e;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mspp_reg_req_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic data_oe;
   } mspp_ext_bus_s;

   typedef struct packed {
      logic [5:0] en;
      logic [5:0] out;
      logic [5:0] oe;
   } mspp_serial_alt_s;

endpackage

// file: mspp_bidir_port.sv
// Pin driver slice for one bidirectional port with open-drain option
`timescale 1ns/1ps
`default_nettype none

module mspp_bidir_port #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Software state
   input wire logic [W-1:0] latch,
   input wire logic [W-1:0] dir,
   input wire logic open_drain,
   // Alternate function per pin
   input wire logic [W-1:0] alt_en,
   input wire logic [W-1:0] alt_out,
   input wire logic [W-1:0] alt_oe,
   // Pins
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe,
   // Value seen by a register read
   output logic [W-1:0] read_value
);

   logic [W-1:0] drv_val;
   logic [W-1:0] drv_en;
   logic [W-1:0] next_out;
   logic [W-1:0] next_oe;

   // ****************************************
   // Driver selection
   // ****************************************
   always_comb begin
      drv_val = (alt_en & alt_out) | (~alt_en & latch);
      drv_en = (alt_en & alt_oe) | (~alt_en & dir);
      // Open drain: only the low side drives, a one floats
      if (open_drain) begin
         next_out = '0;
         next_oe = drv_en & ~drv_val;
      end else begin
         next_out = drv_val;
         next_oe = drv_en;
      end
   end

   // Inputs read the pin, outputs read the driver input
   assign read_value = (dir & latch) | (~dir & pin_in);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
      end
   end

endmodule

`default_nettype wire

// file: mspp_ports.sv
// Five mode-shared parallel ports with their software registers
//
// Operation
// - High port: 8 outputs, general purpose in single-chip, upper address in expanded.
// - High port read always returns the registered pin level, never the latch.
// - High port writes are latched; latch reaches pins only in single-chip or bootstrap.
// - Data-bus port: 8-bit latch and direction; general I/O or data bus by mode.
// - Data-bus port read: input pins give pin level, outputs give driver input.
// - Data-bus latch drives a pin only if output and single-chip or bootstrap.
// - Out of reset: inputs in single-chip/bootstrap, data bus in expanded/test.
// - Data-bus open-drain bit: zero drives low, one floats the pin.
// - Data-bus open-drain works only in single-chip or bootstrap mode.
// - Serial port: 6 bits, latch and direction, shared with both serial units.
// - Serial port read: inputs give pin level, outputs give driver input.
// - Serial latch drives a pin only when it is a general-purpose output.
// - Serial open-drain bit in sync serial control applies in every mode.
// - Analog port: 8 inputs; pins unused by the converter read as inputs.
// - Low port: 8 outputs, general purpose in single-chip, lower address in expanded.
// - Low port read returns the registered pin level; latch reaches pins in single-chip or bootstrap.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mspp_defines.svh"

module mspp_ports (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Mode strap, caught while reset is high
   input wire logic [1:0] mode_strap,
   // Register port
   input wire mspp_pkg::mspp_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   // Expanded bus from the core
   input wire mspp_pkg::mspp_ext_bus_s ext_bus,
   output logic [7:0] ext_data_in,
   // Serial units and converter
   input wire mspp_pkg::mspp_serial_alt_s serial_alt,
   input wire logic [7:0] adc_in_use,
   // Output-only ports
   output logic [7:0] high_address_port_pins,
   output logic [7:0] low_address_port_pins,
   // Data-bus port pins
   input wire logic [7:0] data_bus_port_pins_in,
   output logic [7:0] data_bus_port_pins_out,
   output logic [7:0] data_bus_port_pins_oe,
   // Serial-shared port pins
   input wire logic [5:0] serial_shared_port_pins_in,
   output logic [5:0] serial_shared_port_pins_out,
   output logic [5:0] serial_shared_port_pins_oe,
   // Analog-shared port pins
   input wire logic [7:0] analog_shared_port_input
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic is_gp_mode(mspp_pkg::mspp_mode_e m);
      return (m == mspp_pkg::MODE_SINGLE) || (m == mspp_pkg::MODE_BOOT);
   endfunction

   function automatic mspp_pkg::mspp_mode_e strap_to_mode(logic [1:0] s);
      mspp_pkg::mspp_mode_e m;
      m = mspp_pkg::MODE_SINGLE;
      unique case (s)
         `MSPP_STRAP_BOOT: m = mspp_pkg::MODE_BOOT;
         `MSPP_STRAP_SINGLE: m = mspp_pkg::MODE_SINGLE;
         `MSPP_STRAP_TEST: m = mspp_pkg::MODE_TEST;
         `MSPP_STRAP_EXP: m = mspp_pkg::MODE_EXPANDED;
      endcase
      return m;
   endfunction

   function automatic logic wr_hit(mspp_pkg::mspp_reg_req_s r, logic [3:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction

   // ****************************************
   // State
   // ****************************************
   mspp_pkg::mspp_mode_e mode;
   logic gp_mode;
   logic [7:0] high_address_port_latch;
   logic [7:0] low_address_port_latch;
   logic [7:0] data_bus_port_latch;
   logic [7:0] data_bus_port_direction;
   logic [5:0] serial_shared_port_latch;
   logic [5:0] serial_shared_port_direction;
   logic [7:0] second_option_register;
   logic [7:0] sync_serial_control_register;
   logic data_bus_port_open_drain;
   logic serial_shared_port_open_drain;
   logic [7:0] dbus_read;
   logic [5:0] ser_read;
   logic [7:0] analog_read;
   logic [7:0] next_rdata;
   logic [7:0] next_high;
   logic [7:0] next_low;

   // ****************************************
   // Operating mode
   // ****************************************
   // Strap sampled during synchronous reset; held afterwards
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode <= strap_to_mode(mode_strap);
      end
   end

   assign gp_mode = is_gp_mode(mode);

   // ****************************************
   // Output-only ports
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         high_address_port_latch <= `MSPP_RST_LATCH;
         low_address_port_latch <= `MSPP_RST_LATCH;
      end else begin
         if (wr_hit(reg_req, `MSPP_OFS_HIGH_LATCH)) begin
            high_address_port_latch <= reg_req.wdata;
         end
         if (wr_hit(reg_req, `MSPP_OFS_LOW_LATCH)) begin
            low_address_port_latch <= reg_req.wdata;
         end
      end
   end

   // Latch only in single-chip or bootstrap; address otherwise
   assign next_high = gp_mode ? high_address_port_latch : ext_bus.addr[15:8];
   assign next_low = gp_mode ? low_address_port_latch : ext_bus.addr[7:0];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         high_address_port_pins <= `MSPP_RST_LATCH;
         low_address_port_pins <= `MSPP_RST_LATCH;
      end else begin
         high_address_port_pins <= next_high;
         low_address_port_pins <= next_low;
      end
   end

   // ****************************************
   // Data-bus and serial port registers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_bus_port_latch <= `MSPP_RST_LATCH;
         data_bus_port_direction <= `MSPP_RST_DIR;
      end else begin
         if (wr_hit(reg_req, `MSPP_OFS_DBUS_LATCH)) begin
            data_bus_port_latch <= reg_req.wdata;
         end
         if (wr_hit(reg_req, `MSPP_OFS_DBUS_DIR)) begin
            data_bus_port_direction <= reg_req.wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         serial_shared_port_latch <= `MSPP_RST_SER;
         serial_shared_port_direction <= `MSPP_RST_SER;
      end else begin
         if (wr_hit(reg_req, `MSPP_OFS_SER_LATCH)) begin
            serial_shared_port_latch <= reg_req.wdata[5:0];
         end
         if (wr_hit(reg_req, `MSPP_OFS_SER_DIR)) begin
            serial_shared_port_direction <= reg_req.wdata[5:0];
         end
      end
   end

   // ****************************************
   // Open-drain controls
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         second_option_register <= `MSPP_RST_CTRL;
         sync_serial_control_register <= `MSPP_RST_CTRL;
      end else begin
         if (wr_hit(reg_req, `MSPP_OFS_OPTION2)) begin
            second_option_register <= reg_req.wdata;
         end
         if (wr_hit(reg_req, `MSPP_OFS_SYNC_CTRL)) begin
            sync_serial_control_register <= reg_req.wdata;
         end
      end
   end

   // Wired-OR on the data bus would corrupt expanded cycles
   assign data_bus_port_open_drain =
      second_option_register[`MSPP_DBUS_OD_BIT] && gp_mode;
   assign serial_shared_port_open_drain =
      sync_serial_control_register[`MSPP_SER_OD_BIT];

   // ****************************************
   // Pin drivers
   // ****************************************
   // Expanded and test modes hand every pin to the bus
   mspp_bidir_port #(.W(`MSPP_DBUS_W)) u_dbus (
      .clk_sys(clk_sys),
      .rst(rst),
      .latch(data_bus_port_latch),
      .dir(data_bus_port_direction),
      .open_drain(data_bus_port_open_drain),
      .alt_en({8{~gp_mode}}),
      .alt_out(ext_bus.data),
      .alt_oe({8{ext_bus.data_oe}}),
      .pin_in(data_bus_port_pins_in),
      .pin_out(data_bus_port_pins_out),
      .pin_oe(data_bus_port_pins_oe),
      .read_value(dbus_read)
   );

   mspp_bidir_port #(.W(`MSPP_SER_W)) u_ser (
      .clk_sys(clk_sys),
      .rst(rst),
      .latch(serial_shared_port_latch),
      .dir(serial_shared_port_direction),
      .open_drain(serial_shared_port_open_drain),
      .alt_en(serial_alt.en),
      .alt_out(serial_alt.out),
      .alt_oe(serial_alt.oe),
      .pin_in(serial_shared_port_pins_in),
      .pin_out(serial_shared_port_pins_out),
      .pin_oe(serial_shared_port_pins_oe),
      .read_value(ser_read)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_data_in <= `MSPP_RST_LATCH;
      end else begin
         ext_data_in <= data_bus_port_pins_in;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Converter-owned pins read zero; sampling-phase reads left to software
   assign analog_read = analog_shared_port_input & ~adc_in_use;

   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_req.addr)
         `MSPP_OFS_HIGH_LATCH: next_rdata = high_address_port_pins;
         `MSPP_OFS_LOW_LATCH: next_rdata = low_address_port_pins;
         `MSPP_OFS_DBUS_LATCH: next_rdata = dbus_read;
         `MSPP_OFS_DBUS_DIR: next_rdata = data_bus_port_direction;
         `MSPP_OFS_SER_LATCH: next_rdata = {2'h0, ser_read};
         `MSPP_OFS_SER_DIR: next_rdata = {2'h0, serial_shared_port_direction};
         `MSPP_OFS_ANALOG_IN: next_rdata = analog_read;
         `MSPP_OFS_OPTION2: next_rdata = second_option_register;
         `MSPP_OFS_SYNC_CTRL: next_rdata = sync_serial_control_register;
         `MSPP_OFS_MODE: next_rdata = {4'h0, mode};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_req.rd ? next_rdata : 8'h00;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_high_port_gpio: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_hit(reg_req, `MSPP_OFS_HIGH_LATCH) && gp_mode)
      |-> ##2 high_address_port_pins == $past(reg_req.wdata, 2))
      else $error("high port latch did not reach pins");

   a_high_port_addr: assert property (@(posedge clk_sys) disable iff (rst)
      !gp_mode |=> high_address_port_pins == $past(ext_bus.addr[15:8]))
      else $error("high port not carrying upper address");

   a_low_port_addr: assert property (@(posedge clk_sys) disable iff (rst)
      !gp_mode |=> low_address_port_pins == $past(ext_bus.addr[7:0]))
      else $error("low port not carrying lower address");

   a_high_read_drv: assert property (@(posedge clk_sys) disable iff (rst)
      (reg_req.rd && reg_req.addr == `MSPP_OFS_HIGH_LATCH)
      |=> reg_rdata == $past(high_address_port_pins))
      else $error("high port read not driver level");

   // One edge after release, so direction and mode decide rather than the reset branch
   a_dbus_reset_input: assert property (@(posedge clk_sys)
      ($fell(rst) && gp_mode) |=> data_bus_port_pins_oe == 8'h00)
      else $error("data bus pins driven right after reset");

   a_dbus_open_drain: assert property (@(posedge clk_sys) disable iff (rst)
      (data_bus_port_open_drain && !$rose(gp_mode))
      |=> data_bus_port_pins_out == 8'h00
          && (data_bus_port_pins_oe & $past(data_bus_port_latch)) == 8'h00)
      else $error("open-drain data bus drove high");

   a_dbus_bus_mode: assert property (@(posedge clk_sys) disable iff (rst)
      !gp_mode |=> data_bus_port_pins_oe == {8{$past(ext_bus.data_oe)}}
                   && data_bus_port_pins_out == $past(ext_bus.data))
      else $error("data bus pins not following expanded bus");

   a_dbus_gpio_out: assert property (@(posedge clk_sys) disable iff (rst)
      (gp_mode && !second_option_register[`MSPP_DBUS_OD_BIT])
      |=> data_bus_port_pins_oe == $past(data_bus_port_direction))
      else $error("data bus enable not following direction");

   a_ser_open_drain: assert property (@(posedge clk_sys) disable iff (rst)
      serial_shared_port_open_drain |=> serial_shared_port_pins_out == 6'h00)
      else $error("open-drain serial port drove high");

   a_ser_read_pin: assert property (@(posedge clk_sys) disable iff (rst)
      (reg_req.rd && reg_req.addr == `MSPP_OFS_SER_LATCH
       && serial_shared_port_direction == 6'h00)
      |=> reg_rdata[5:0] == $past(serial_shared_port_pins_in))
      else $error("serial input read not pin level");

   a_analog_read: assert property (@(posedge clk_sys) disable iff (rst)
      (reg_req.rd && reg_req.addr == `MSPP_OFS_ANALOG_IN)
      |=> reg_rdata == $past(analog_shared_port_input & ~adc_in_use))
      else $error("analog port read wrong");

   c_high_gpio_write: cover property (@(posedge clk_sys) disable iff (rst)
      wr_hit(reg_req, `MSPP_OFS_HIGH_LATCH) && gp_mode);

   c_dbus_expanded_drive: cover property (@(posedge clk_sys) disable iff (rst)
      !gp_mode && ext_bus.data_oe);

   c_dbus_open_drain: cover property (@(posedge clk_sys) disable iff (rst)
      data_bus_port_open_drain && (data_bus_port_direction != 8'h00));

   c_serial_alt_use: cover property (@(posedge clk_sys) disable iff (rst)
      serial_alt.en != 6'h00);

endmodule

`default_nettype wire

// file: mspp_pins_model.sv
// Far-side circuitry model for one bidirectional port: drivers and pull-ups
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Pin partner
// ****************************************
module mspp_pins_model #(
   parameter int W = 8
) (
   // Chip side
   input wire logic [W-1:0] chip_out,
   input wire logic [W-1:0] chip_oe,
   // Far-side drivers
   input wire logic [W-1:0] far_en,
   input wire logic [W-1:0] far_val,
   // Resolved wire level
   output logic [W-1:0] level
);
   // Pull-up holds a released wire high, so a floating open-drain pin reads one
   assign level = (chip_oe & chip_out) | (~chip_oe & far_en & far_val) | (~chip_oe & ~far_en);
endmodule

`default_nettype wire

// file: mspp_ports_test.sv
// Self-checking testbench for the mode-shared parallel ports
`timescale 1ns/1ps
`default_nettype none
`include "mspp_defines.svh"

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end

module mspp_ports_test;
   logic clk_sys, rst, od, so, gp;
   logic [1:0] mode_strap;
   mspp_pkg::mspp_reg_req_s reg_req;
   mspp_pkg::mspp_ext_bus_s ext_bus;
   mspp_pkg::mspp_serial_alt_s serial_alt;
   mspp_pkg::mspp_mode_e mexp;
   logic [7:0] reg_rdata, ext_data_in, adc_in_use, analog, hi_pins, lo_pins, d;
   logic [7:0] db_in, db_out, db_oe, db_en, db_val, hl, ll, dl, dd, hi_e, lo_e, dbo_e, dbv_e;
   logic [5:0] sp_in, sp_out, sp_oe, sp_en, sp_val, sl, sd, se, sv, spo_e, spv_e;
   int n_fail, comparisons, seed;

   mspp_ports dut (.clk_sys(clk_sys), .rst(rst), .mode_strap(mode_strap), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .ext_bus(ext_bus), .ext_data_in(ext_data_in),
      .serial_alt(serial_alt), .adc_in_use(adc_in_use), .high_address_port_pins(hi_pins),
      .low_address_port_pins(lo_pins), .data_bus_port_pins_in(db_in),
      .data_bus_port_pins_out(db_out), .data_bus_port_pins_oe(db_oe),
      .serial_shared_port_pins_in(sp_in), .serial_shared_port_pins_out(sp_out),
      .serial_shared_port_pins_oe(sp_oe), .analog_shared_port_input(analog));
   mspp_pins_model #(.W(8)) dbus_far (.chip_out(db_out), .chip_oe(db_oe), .far_en(db_en),
      .far_val(db_val), .level(db_in));
   mspp_pins_model #(.W(6)) ser_far (.chip_out(sp_out), .chip_oe(sp_oe), .far_en(sp_en),
      .far_val(sp_val), .level(sp_in));

   // ****************************************
   // Expectations, bus tasks and closing report
   // ****************************************
   // Per bit: a where sel is set, b elsewhere
   function automatic logic [7:0] pick(input logic [7:0] sel, input logic [7:0] a,
      input logic [7:0] b);
      return (sel & a) | (~sel & b);
   endfunction

   // Open drain enables only the zeros of the value
   function automatic logic [7:0] od_oe(input logic od_on, input logic [7:0] en,
      input logic [7:0] val);
      return od_on ? (en & ~val) : en;
   endfunction

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      reg_req <= '0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      reg_req <= '0;
      #1 v = reg_rdata;
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Guards against a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      conclude();
   end

   // ****************************************
   // Main sequence, one pass per mode strap
   // ****************************************
   initial begin
      seed = 61;
      n_fail = 0;
      comparisons = 0;
      rst = 1'b1;
      mode_strap = 2'h0;
      reg_req = '0;
      ext_bus = '0;
      serial_alt = '0;
      adc_in_use = 8'h00;
      analog = 8'h00;
      {db_en, db_val, sp_en, sp_val} = '0;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys);
         rst <= 1'b1;
         mode_strap <= 2'(m);
         repeat (20) @(posedge clk_sys);
         rst <= 1'b0;
         #1;
         mexp = (m == 0) ? mspp_pkg::MODE_BOOT : (m == 1) ? mspp_pkg::MODE_SINGLE :
            (m == 2) ? mspp_pkg::MODE_TEST : mspp_pkg::MODE_EXPANDED;
         gp = (m < 2);
         `CHK({db_oe, sp_oe}, 14'h0000)
         rd(`MSPP_OFS_DBUS_DIR, d); `CHK(d, 8'h00)
         rd(`MSPP_OFS_SER_DIR, d); `CHK(d, 8'h00)
         rd(`MSPP_OFS_OPTION2, d); `CHK(d, 8'h00)
         rd(`MSPP_OFS_SYNC_CTRL, d); `CHK(d, 8'h00)
         wr(`MSPP_OFS_MODE, 8'hFF);
         wr(`MSPP_OFS_ANALOG_IN, 8'hFF);
         rd(`MSPP_OFS_MODE, d); `CHK(d, 8'(mexp))
         rd(4'hC, d); `CHK(d, 8'h00)
         for (int i = 0; i < 6; i++) begin
            {hl, ll, dl, dd} = 32'($random(seed));
            {sl, sd, od, so} = 14'($random(seed));
            // Corners: all outputs with open drain, then all inputs
            if (i == 0) {dd, sd, dl, od, so} = {8'hFF, 6'h3F, 8'h5A, 2'h3};
            if (i == 1) {dd, sd} = 14'h0000;
            @(posedge clk_sys);
            ext_bus <= 25'($random(seed));
            serial_alt <= 18'($random(seed));
            {adc_in_use, analog, db_en, db_val} <= 32'($random(seed));
            {sp_en, sp_val} <= 12'($random(seed));
            wr(`MSPP_OFS_HIGH_LATCH, hl);
            wr(`MSPP_OFS_LOW_LATCH, ll);
            wr(`MSPP_OFS_DBUS_LATCH, dl);
            wr(`MSPP_OFS_DBUS_DIR, dd);
            wr(`MSPP_OFS_SER_LATCH, {2'b00, sl});
            wr(`MSPP_OFS_SER_DIR, {2'b00, sd});
            wr(`MSPP_OFS_OPTION2, 8'(od) << `MSPP_DBUS_OD_BIT);
            wr(`MSPP_OFS_SYNC_CTRL, 8'(so) << `MSPP_SER_OD_BIT);
            repeat (2) @(posedge clk_sys);
            #1;
            hi_e = gp ? hl : ext_bus.addr[15:8];
            lo_e = gp ? ll : ext_bus.addr[7:0];
            dbo_e = gp ? od_oe(od, dd, dl) : {8{ext_bus.data_oe}};
            dbv_e = gp ? (od ? 8'h00 : dl) : ext_bus.data;
            sv = 6'(pick({2'h0, serial_alt.en}, {2'h0, serial_alt.out}, {2'h0, sl}));
            se = 6'(pick({2'h0, serial_alt.en}, {2'h0, serial_alt.oe}, {2'h0, sd}));
            spo_e = 6'(od_oe(so, {2'h0, se}, {2'h0, sv}));
            spv_e = so ? 6'h00 : sv;
            `CHK(hi_pins, hi_e)
            `CHK(lo_pins, lo_e)
            `CHK(db_oe, dbo_e)
            `CHK(db_out & db_oe, dbv_e & dbo_e)
            `CHK(ext_data_in, db_in)
            `CHK(sp_oe, spo_e)
            `CHK(sp_out & sp_oe, spv_e & spo_e)
            rd(`MSPP_OFS_HIGH_LATCH, d); `CHK(d, hi_e)
            rd(`MSPP_OFS_LOW_LATCH, d); `CHK(d, lo_e)
            rd(`MSPP_OFS_DBUS_LATCH, d); `CHK(d, pick(dd, dl, db_in))
            rd(`MSPP_OFS_SER_LATCH, d); `CHK(d, pick({2'h0, sd}, {2'h0, sl}, {2'h0, sp_in}))
            // No conversion is modelled, so this read never falls in a sampling phase
            rd(`MSPP_OFS_ANALOG_IN, d); `CHK(d, analog & ~adc_in_use)
            rd(`MSPP_OFS_DBUS_DIR, d); `CHK(d, dd)
         end
      end
      conclude();
   end
endmodule

`default_nettype wire
